// ### hw/bfc_port_control.sv
// Notes on behaviour
// - Reset may change at any moment; it is synchronised inside.
// - Reset clears pointers; full, empty, almost-empty low; almost-full high.
// - Reset sets both mail flags high, meaning no new mail.
// - Full flags go high on the second port clock edge after reset release.
// - Offset selects are captured into the offset register at reset release.
// - Offset is 16, 12, 8 or 4 for selects HH, HL, LH, LL.
// - Port A bus drives only while its chip select and write/read are low.
// - Port A write to A-to-B queue needs select, write, enable, no mailbox, not full.
// - Port A read from B-to-A queue needs select, read, enable, no mailbox, not empty.
// - Port B bus drives only while its chip select and write/read are low.
// - Port B queue write needs select, write, enable, a size low, not full.
// - Port B queue read needs select, read, enable, not empty, a size low.
// - Chip select and write/read count for transfers only in cycles with enable high; bus drive ignores enable.
// - Every queue status flag passes two flip-flop stages before the pin.
// - Each port's flags change only on that port's clock edges.
// - Port A sets A-to-B mail or clears B-to-A mail; port B mirrors.
// - Port A mailbox write shows on port B bus when it reads mail.
// - Port B mailbox write shows on port A bus when it reads mail.
// - Parity error flags follow only bus and odd/even, not controls; parity bits 8,17,26,35.
// - Generated parity replaces parity bits only on mailbox reads.
// - Port B parity flag re-evaluates on the edge applying a new size.
// - Port B write with both sizes high fills mailbox; blocked while flag low.
// - Writes to a full queue are ignored; contents and pointer kept.
`timescale 1ns/10ps
module bfc_port_control import bfc_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Offset preset and parity sense
  input wire logic offset_select_hi,
  input wire logic offset_select_lo,
  input wire logic parity_odd_select,
  // Port A controls
  input wire bfc_port_a_ctl_type port_a_ctl,
  input wire logic port_a_parity_generate,
  // Port A data pins
  input wire logic [DATA_W-1:0] port_a_data_in,
  output logic [DATA_W-1:0] port_a_data_out,
  output logic port_a_data_oe_n,
  // Port A status
  output bfc_flags_type port_a_flags,
  output logic port_a_parity_error_n,
  output logic a_to_b_mail_flag,
  // Port B controls
  input wire bfc_port_b_ctl_type port_b_ctl,
  input wire logic port_b_parity_generate,
  // Port B data pins
  input wire logic [DATA_W-1:0] port_b_data_in,
  output logic [DATA_W-1:0] port_b_data_out,
  output logic port_b_data_oe_n,
  // Port B status
  output bfc_flags_type port_b_flags,
  output logic port_b_parity_error_n,
  output logic b_to_a_mail_flag
);

  // Reset synchroniser
  logic rst_meta_r;
  logic rst_sync_n;

  // Offset register
  logic rst_seen_r;
  logic [LEVEL_W-1:0] offset_r;
  logic [LEVEL_W-1:0] offset_nxt;

  // Queue handshakes
  logic ab_in_ready;
  logic ab_out_valid;
  logic [DATA_W-1:0] ab_out_data;
  logic [LEVEL_W-1:0] ab_level;
  logic ba_in_ready;
  logic ba_out_valid;
  logic [DATA_W-1:0] ba_out_data;
  logic [LEVEL_W-1:0] ba_level;

  // Decoded port operations
  logic a_sel;
  logic a_wr_queue;
  logic a_rd_queue;
  logic a_wr_mail;
  logic a_rd_mail;
  logic b_sel;
  logic b_mail_size;
  logic b_wr_queue;
  logic b_rd_queue;
  logic b_wr_mail;
  logic b_rd_mail;

  // Flags and mailboxes
  bfc_flags_type a_flags_s1_r;
  bfc_flags_type a_flags_r;
  bfc_flags_type b_flags_s1_r;
  bfc_flags_type b_flags_r;
  logic ab_mail_flag_r;
  logic ba_mail_flag_r;
  logic [DATA_W-1:0] ab_mailbox_r;
  logic [DATA_W-1:0] ba_mailbox_r;

  // Port B size applied at the clock edge
  logic b_size_hi_r;
  logic b_size_lo_r;
  logic b_mail_view;

  // Bus words
  logic [DATA_W-1:0] a_word;
  logic [DATA_W-1:0] b_word;

  function automatic bfc_flags_type level_flags(
    input logic [LEVEL_W-1:0] wr_level,
    input logic [LEVEL_W-1:0] rd_level,
    input logic [LEVEL_W-1:0] offset
  );
    bfc_flags_type f;
    f.empty_n = (rd_level != LEVEL_EMPTY);
    f.almost_empty_n = (rd_level > offset);
    f.full_n = (wr_level != LEVEL_FULL);
    f.almost_full_n = (wr_level < LEVEL_W'(LEVEL_FULL - offset));
    return f;
  endfunction : level_flags

  function automatic logic [DATA_W-1:0] insert_parity(
    input logic [DATA_W-1:0] word,
    input logic odd
  );
    logic [DATA_W-1:0] w;
    w = word;
    for (int i = 0; i < LANES; i++) begin
      w[i*LANE_W+PARITY_POS] = (^word[i*LANE_W +: PARITY_POS]) ^ odd;
    end
    return w;
  endfunction : insert_parity

  function automatic logic parity_ok(
    input logic [DATA_W-1:0] word,
    input logic odd
  );
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < LANES; i++) begin
      if ((^word[i*LANE_W +: LANE_W]) != odd) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction : parity_ok

  // Reset enters at once, leaves in step with the clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_r <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_n <= rst_meta_r;
    end
  end

  always_comb begin
    unique case ({offset_select_hi, offset_select_lo})
      2'b11: offset_nxt = OFFSET_HH;
      2'b10: offset_nxt = OFFSET_HL;
      2'b01: offset_nxt = OFFSET_LH;
      2'b00: offset_nxt = OFFSET_LL;
    endcase
  end

  // Offset caught on the first edge after reset release
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rst_seen_r <= 1'b0;
      offset_r <= OFFSET_LL;
    end else begin
      rst_seen_r <= 1'b1;
      if (!rst_seen_r) begin
        offset_r <= offset_nxt;
      end
    end
  end

  // Port A decode
  assign a_sel = ~port_a_ctl.cs_n & port_a_ctl.enable;
  assign a_wr_queue = a_sel & port_a_ctl.write_not_read & ~port_a_ctl.mailbox_select
    & a_flags_r.full_n & ab_in_ready;
  assign a_rd_queue = a_sel & ~port_a_ctl.write_not_read & ~port_a_ctl.mailbox_select
    & a_flags_r.empty_n & ba_out_valid;
  assign a_wr_mail = a_sel & port_a_ctl.write_not_read & port_a_ctl.mailbox_select
    & (ab_mail_flag_r == MAIL_NONE);
  assign a_rd_mail = a_sel & ~port_a_ctl.write_not_read & port_a_ctl.mailbox_select;

  // Port B decode
  assign b_sel = ~port_b_ctl.cs_n & port_b_ctl.enable;
  assign b_mail_size = port_b_ctl.size_hi & port_b_ctl.size_lo;
  assign b_wr_queue = b_sel & port_b_ctl.write_not_read & ~b_mail_size
    & b_flags_r.full_n & ba_in_ready;
  assign b_rd_queue = b_sel & ~port_b_ctl.write_not_read & ~b_mail_size
    & b_flags_r.empty_n & ab_out_valid;
  assign b_wr_mail = b_sel & port_b_ctl.write_not_read & b_mail_size
    & (ba_mail_flag_r == MAIL_NONE);
  assign b_rd_mail = b_sel & ~port_b_ctl.write_not_read & b_mail_size;

  bfc_queue #(
    .WIDTH(DATA_W),
    .DEPTH(QUEUE_DEPTH),
    .CW(LEVEL_W)
  ) u_a_to_b_queue (
    .clk(clk),
    .rst_n(rst_sync_n),
    .in_valid(a_wr_queue),
    .in_ready(ab_in_ready),
    .in_data(port_a_data_in),
    .out_valid(ab_out_valid),
    .out_ready(b_rd_queue),
    .out_data(ab_out_data),
    .level(ab_level)
  );

  bfc_queue #(
    .WIDTH(DATA_W),
    .DEPTH(QUEUE_DEPTH),
    .CW(LEVEL_W)
  ) u_b_to_a_queue (
    .clk(clk),
    .rst_n(rst_sync_n),
    .in_valid(b_wr_queue),
    .in_ready(ba_in_ready),
    .in_data(port_b_data_in),
    .out_valid(ba_out_valid),
    .out_ready(a_rd_queue),
    .out_data(ba_out_data),
    .level(ba_level)
  );

  // Port A flags: writes A-to-B, reads B-to-A
  // Reset straight from the pin; the two stages retime the release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      a_flags_s1_r <= FLAGS_RESET;
      a_flags_r <= FLAGS_RESET;
    end else begin
      a_flags_s1_r <= level_flags(ab_level, ba_level, offset_r);
      a_flags_r <= a_flags_s1_r;
    end
  end

  // Port B flags: writes B-to-A, reads A-to-B
  // Full flag rises on the second edge after release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      b_flags_s1_r <= FLAGS_RESET;
      b_flags_r <= FLAGS_RESET;
    end else begin
      b_flags_s1_r <= level_flags(ba_level, ab_level, offset_r);
      b_flags_r <= b_flags_s1_r;
    end
  end

  // A-to-B mailbox: filled by port A, emptied by port B
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ab_mail_flag_r <= MAIL_NONE;
      ab_mailbox_r <= DATA_RESET;
    end else if (a_wr_mail) begin
      ab_mail_flag_r <= MAIL_NEW;
      ab_mailbox_r <= port_a_data_in;
    end else if (b_rd_mail) begin
      ab_mail_flag_r <= MAIL_NONE;
    end
  end

  // B-to-A mailbox: filled by port B, emptied by port A
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ba_mail_flag_r <= MAIL_NONE;
      ba_mailbox_r <= DATA_RESET;
    end else if (b_wr_mail) begin
      ba_mail_flag_r <= MAIL_NEW;
      ba_mailbox_r <= port_b_data_in;
    end else if (a_rd_mail) begin
      ba_mail_flag_r <= MAIL_NONE;
    end
  end

  // Port B bus size takes effect at the clock edge
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      b_size_hi_r <= 1'b0;
      b_size_lo_r <= 1'b0;
    end else begin
      b_size_hi_r <= port_b_ctl.size_hi;
      b_size_lo_r <= port_b_ctl.size_lo;
    end
  end

  assign b_mail_view = b_size_hi_r & b_size_lo_r;

  // Port A read data: queue output or mailbox with optional parity
  always_comb begin
    if (port_a_ctl.mailbox_select) begin
      a_word = ba_mailbox_r;
      if (port_a_parity_generate) begin
        a_word = insert_parity(ba_mailbox_r, parity_odd_select);
      end
    end else begin
      a_word = ba_out_data;
    end
  end

  // Port B read data: queue output or mailbox with optional parity
  always_comb begin
    if (b_mail_view) begin
      b_word = ab_mailbox_r;
      if (port_b_parity_generate) begin
        b_word = insert_parity(ab_mailbox_r, parity_odd_select);
      end
    end else begin
      b_word = ab_out_data;
    end
  end

  // Pin drive
  assign port_a_data_out = a_word;
  assign port_a_data_oe_n = port_a_ctl.cs_n | port_a_ctl.write_not_read;
  assign port_b_data_out = b_word;
  assign port_b_data_oe_n = port_b_ctl.cs_n | port_b_ctl.write_not_read;

  // Passive parity check on the resolved bus
  assign port_a_parity_error_n = parity_ok(port_a_data_in, parity_odd_select);
  assign port_b_parity_error_n = parity_ok(port_b_data_in, parity_odd_select);

  // Status pins
  assign port_a_flags = a_flags_r;
  assign port_b_flags = b_flags_r;
  assign a_to_b_mail_flag = ab_mail_flag_r;
  assign b_to_a_mail_flag = ba_mail_flag_r;

endmodule : bfc_port_control

// ### shared/bfc_pkg.sv
package bfc_pkg;

  // Datapath geometry
  localparam int DATA_W = 36;
  localparam int LANE_W = 9;
  localparam int LANES = 4;
  localparam int PARITY_POS = 8;
  localparam int QUEUE_DEPTH = 32;
  localparam int LEVEL_W = 6;

  // Almost-full / almost-empty offset presets
  localparam logic [LEVEL_W-1:0] OFFSET_HH = 6'h10;
  localparam logic [LEVEL_W-1:0] OFFSET_HL = 6'h0c;
  localparam logic [LEVEL_W-1:0] OFFSET_LH = 6'h08;
  localparam logic [LEVEL_W-1:0] OFFSET_LL = 6'h04;
  localparam logic [LEVEL_W-1:0] LEVEL_FULL = 6'h20;
  localparam logic [LEVEL_W-1:0] LEVEL_EMPTY = 6'h00;

  typedef struct packed {
    logic cs_n;
    logic write_not_read;
    logic enable;
    logic mailbox_select;
  } bfc_port_a_ctl_type;

  typedef struct packed {
    logic cs_n;
    logic write_not_read;
    logic enable;
    logic size_hi;
    logic size_lo;
  } bfc_port_b_ctl_type;

  // All flags active low, as on the pins
  typedef struct packed {
    logic empty_n;
    logic almost_empty_n;
    logic full_n;
    logic almost_full_n;
  } bfc_flags_type;

  localparam bfc_flags_type FLAGS_RESET = '{
    empty_n: 1'b0, almost_empty_n: 1'b0, full_n: 1'b0, almost_full_n: 1'b1};
  localparam logic MAIL_NONE = 1'b1;
  localparam logic MAIL_NEW = 1'b0;
  localparam logic [DATA_W-1:0] DATA_RESET = 36'h0_0000_0000;

endpackage : bfc_pkg

// ### hw/bfc_queue.sv
`timescale 1ns/10ps
module bfc_queue import bfc_pkg::*; #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 32,
  parameter int CW = 6
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // Fill level
  output logic [CW-1:0] level
);

  localparam int PW = $clog2(DEPTH);
  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr_r;
  logic [PW-1:0] rd_ptr_r;
  logic [CW-1:0] count_r;
  logic [WIDTH-1:0] out_data_r;
  logic push;
  logic pop;

  assign in_ready = (count_r != DEPTH_C);
  assign out_valid = (count_r != '0);
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = out_data_r;
  assign level = count_r;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= PW'(wr_ptr_r + 1'b1);
      end
      if (pop) begin
        rd_ptr_r <= PW'(rd_ptr_r + 1'b1);
      end
      if (push && !pop) begin
        count_r <= CW'(count_r + 1'b1);
      end else if (pop && !push) begin
        count_r <= CW'(count_r - 1'b1);
      end
    end
  end

  // Output register takes the next word on each pop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_data_r <= '0;
    end else if (pop) begin
      out_data_r <= mem[rd_ptr_r];
    end
  end

endmodule : bfc_queue

// ### testbench/bfc_port_control_chk.sv
`timescale 1ns/10ps
module bfc_port_control_chk import bfc_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Port A
  input wire bfc_port_a_ctl_type port_a_ctl,
  input wire logic port_a_data_oe_n,
  input wire bfc_flags_type port_a_flags,
  input wire logic a_to_b_mail_flag,
  // Port B
  input wire bfc_port_b_ctl_type port_b_ctl,
  input wire logic port_b_data_oe_n,
  input wire bfc_flags_type port_b_flags,
  input wire logic b_to_a_mail_flag
);
  logic a_go, b_go, b_mb, a_wq, b_wq, a_mw, a_mr, b_mw, b_mr;
  assign a_go = !port_a_ctl.cs_n && port_a_ctl.enable;
  assign b_go = !port_b_ctl.cs_n && port_b_ctl.enable;
  assign b_mb = port_b_ctl.size_hi && port_b_ctl.size_lo;
  assign a_wq = a_go && port_a_ctl.write_not_read && !port_a_ctl.mailbox_select
    && port_a_flags.full_n;
  assign b_wq = b_go && port_b_ctl.write_not_read && !b_mb && port_b_flags.full_n;
  assign a_mw = a_go && port_a_ctl.write_not_read && port_a_ctl.mailbox_select;
  assign a_mr = a_go && !port_a_ctl.write_not_read && port_a_ctl.mailbox_select;
  assign b_mw = b_go && port_b_ctl.write_not_read && b_mb;
  assign b_mr = b_go && !port_b_ctl.write_not_read && b_mb;

  default clocking cb_chk @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  oe_a_a: assert property (
    port_a_data_oe_n == (port_a_ctl.cs_n | port_a_ctl.write_not_read))
    else $error("port A bus enable wrong");
  oe_b_a: assert property (
    port_b_data_oe_n == (port_b_ctl.cs_n | port_b_ctl.write_not_read))
    else $error("port B bus enable wrong");
  rst_val_a: assert property ($rose(rst_n) |-> port_a_flags == FLAGS_RESET
    && port_b_flags == FLAGS_RESET && a_to_b_mail_flag && b_to_a_mail_flag)
    else $error("reset flag values wrong");
  full_rel_a: assert property ($rose(rst_n) |-> !port_a_flags.full_n [*2]
    ##1 port_a_flags.full_n) else $error("port A full release timing wrong");
  full_rel_b: assert property ($rose(rst_n) |-> !port_b_flags.full_n [*2]
    ##1 port_b_flags.full_n) else $error("port B full release timing wrong");
  mail_set_a: assert property (a_mw && a_to_b_mail_flag |=> !a_to_b_mail_flag)
    else $error("A to B mail flag not set");
  mail_set_b: assert property (b_mw && b_to_a_mail_flag |=> !b_to_a_mail_flag)
    else $error("B to A mail flag not set");
  mail_hold_a: assert property (!a_to_b_mail_flag && !b_mr |=> !a_to_b_mail_flag)
    else $error("A to B mail flag dropped");
  mail_clr_a: assert property (b_mr && $past(b_mb) |=> a_to_b_mail_flag)
    else $error("A to B mail flag not cleared");
  mail_clr_b: assert property (a_mr |=> b_to_a_mail_flag)
    else $error("B to A mail flag not cleared");
  empty_lag_b: assert property ($rose(port_b_flags.empty_n) |-> $past(a_wq, 3))
    else $error("port B empty flag lag wrong");
  empty_lag_a: assert property ($rose(port_a_flags.empty_n) |-> $past(b_wq, 3))
    else $error("port A empty flag lag wrong");

  cover property (a_mw ##1 !a_to_b_mail_flag);
  cover property (b_mr);
  cover property ($rose(port_b_flags.empty_n));
endmodule : bfc_port_control_chk

bind bfc_port_control bfc_port_control_chk u_bfc_port_control_chk (.clk, .rst_n,
  .port_a_ctl, .port_a_data_oe_n, .port_a_flags, .a_to_b_mail_flag, .port_b_ctl,
  .port_b_data_oe_n, .port_b_flags, .b_to_a_mail_flag);

// ### testbench/bfc_bus_host.sv
`timescale 1ns/10ps
module bfc_bus_host import bfc_pkg::*; (
  // Device side
  input wire logic [DATA_W-1:0] dev_out,
  input wire logic dev_oe_n,
  // Host side
  input wire logic [DATA_W-1:0] host_out,
  // Resolved bus
  output logic [DATA_W-1:0] bus
);
  // Host drives whenever the device lets go, so the bus never floats
  assign bus = dev_oe_n ? host_out : dev_out;
endmodule : bfc_bus_host

// ### testbench/bfc_port_control_tb.sv
`timescale 1ns/10ps
module bfc_port_control_tb import bfc_pkg::*;;
  logic clk, rst_n, fs_hi, fs_lo, odd, pg_a, pg_b;
  logic mab, mflag_ba, aoe_n, boe_n, pe_a, pe_b;
  bfc_port_a_ctl_type ca;
  bfc_port_b_ctl_type cb;
  bfc_flags_type fa, fb;
  logic [DATA_W-1:0] ha, hb, ain, bin, aout, bout, q;
  int miscompares, total_checks;

  bfc_port_control u_bfc_port_control (.clk(clk), .rst_n(rst_n), .offset_select_hi(fs_hi),
    .offset_select_lo(fs_lo), .parity_odd_select(odd), .port_a_ctl(ca),
    .port_a_parity_generate(pg_a), .port_a_data_in(ain), .port_a_data_out(aout),
    .port_a_data_oe_n(aoe_n), .port_a_flags(fa), .port_a_parity_error_n(pe_a),
    .a_to_b_mail_flag(mab), .port_b_ctl(cb), .port_b_parity_generate(pg_b),
    .port_b_data_in(bin), .port_b_data_out(bout), .port_b_data_oe_n(boe_n),
    .port_b_flags(fb), .port_b_parity_error_n(pe_b), .b_to_a_mail_flag(mflag_ba));
  bfc_bus_host u_bfc_bus_host_a (.dev_out(aout), .dev_oe_n(aoe_n), .host_out(ha), .bus(ain));
  bfc_bus_host u_bfc_bus_host_b (.dev_out(bout), .dev_oe_n(boe_n), .host_out(hb), .bus(bin));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : conclude

  task automatic check(input string n, input logic [DATA_W-1:0] s, input logic [DATA_W-1:0] e);
    total_checks++;
    if (s !== e) begin
      miscompares++;
      $display("Error: %s expected %h seen %h", n, e, s);
    end
  endtask : check

  function automatic logic [DATA_W-1:0] par(input logic [DATA_W-1:0] w, input logic o);
    for (int l = 0; l < LANES; l++) begin
      w[l*LANE_W+PARITY_POS] = o ^ (^w[l*LANE_W+:PARITY_POS]);
    end
    return w;
  endfunction : par

  // One transfer; the idle that follows keeps the mode bits in place
  task automatic pa(input logic [3:0] c, input logic [DATA_W-1:0] d);
    @(posedge clk);
    ca <= c;
    ha <= d;
    @(posedge clk);
    ca <= {1'b1, c[2], 1'b0, c[0]};
    #1 q = aout;
  endtask : pa

  task automatic pb(input logic [4:0] c, input logic [DATA_W-1:0] d);
    @(posedge clk);
    cb <= c;
    hb <= d;
    @(posedge clk);
    cb <= {1'b1, c[3], 1'b0, c[1:0]};
    #1 q = bout;
  endtask : pb

  task automatic reset(input logic h, input logic l);
    @(posedge clk);
    rst_n <= 1'b0;
    fs_hi <= h;
    fs_lo <= l;
    repeat (8) @(posedge clk);
    check("flags_a", DATA_W'(fa), DATA_W'(FLAGS_RESET));
    check("flags_b", DATA_W'(fb), DATA_W'(FLAGS_RESET));
    check("mail", DATA_W'({mab, mflag_ba}), DATA_W'(2'h3));
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    check("full_b", DATA_W'(fb.full_n), DATA_W'(1'b1));
  endtask : reset

  initial begin : watchdog
    #(50 * 6000);
    miscompares++;
    conclude();
  end

  initial begin : main
    int x;
    logic [DATA_W-1:0] w;
    {rst_n, fs_hi, fs_lo, odd, pg_a, pg_b} = 6'h0c;
    ca = 4'h8;
    cb = 5'h10;
    ha = 36'h0;
    hb = 36'h0;
    for (int k = 0; k < 4; k++) begin
      reset(k[1], k[0]);
      x = 4 + 4 * k;
      repeat (x) pa(4'h6, 36'h0);
      repeat (4) @(posedge clk);
      check("ae_b", DATA_W'(fb.almost_empty_n), DATA_W'(1'b0));
      pa(4'h6, 36'h0);
      repeat (4) @(posedge clk);
      check("ae_b", DATA_W'(fb.almost_empty_n), DATA_W'(1'b1));
      check("af_a", DATA_W'(fa.almost_full_n), DATA_W'(x + 1 < QUEUE_DEPTH - x));
    end
    $display("test offset done");
    reset(1'b0, 1'b0);
    for (int i = 0; i <= QUEUE_DEPTH; i++) pa(4'h6, {28'h9a5c3e1, 8'(i)});
    repeat (4) @(posedge clk);
    check("full_a", DATA_W'(fa.full_n), DATA_W'(1'b0));
    check("af_a", DATA_W'(fa.almost_full_n), DATA_W'(1'b0));
    for (int i = 0; i < QUEUE_DEPTH; i++) begin
      pb(5'h04, 36'h0);
      check("rd_b", q, {28'h9a5c3e1, 8'(i)});
    end
    repeat (3) @(posedge clk);
    pb(5'h04, 36'h0);
    check("rd_b", q, {28'h9a5c3e1, 8'd31});
    check("empty_b", DATA_W'(fb.empty_n), DATA_W'(1'b0));
    repeat (3) pa(4'h4, 36'h1);
    repeat (4) @(posedge clk);
    check("empty_b", DATA_W'(fb.empty_n), DATA_W'(1'b0));
    $display("test a_to_b done");
    for (int i = 0; i < 3; i++) pb(5'h0c, {28'h0c3a5f7, 8'(i)});
    repeat (4) @(posedge clk);
    pg_a <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      pa(4'h2, 36'h0);
      check("rd_a", q, {28'h0c3a5f7, 8'(i)});
    end
    repeat (3) @(posedge clk);
    check("empty_a", DATA_W'(fa.empty_n), DATA_W'(1'b0));
    $display("test b_to_a done");
    pa(4'h7, 36'h1_2345_6789);
    pa(4'h7, 36'h0_0bad_cafe);
    check("mail_ab", DATA_W'(mab), DATA_W'(1'b0));
    pb(5'h13, 36'h0);
    pb(5'h07, 36'h0);
    check("mail_b", q, 36'h1_2345_6789);
    check("mail_ab", DATA_W'(mab), DATA_W'(1'b1));
    pb(5'h0f, 36'h5_0f0f_1234);
    pb(5'h0f, 36'h2_2222_2222);
    check("mail_ba", DATA_W'(mflag_ba), DATA_W'(1'b0));
    pa(4'h3, 36'h0);
    check("mail_a", q, par(36'h5_0f0f_1234, 1'b1));
    check("mail_ba", DATA_W'(mflag_ba), DATA_W'(1'b1));
    $display("test mailbox done");
    for (int k = 0; k < 4; k++) begin
      w = par(36'h3_1c2b_9e47, k[0]);
      if (k[1]) w[12] = ~w[12];
      @(posedge clk);
      odd <= k[0];
      ha <= w;
      hb <= w;
      @(posedge clk);
      #1;
      check("pe_a", DATA_W'(pe_a), DATA_W'(!k[1]));
      check("pe_b", DATA_W'(pe_b), DATA_W'(!k[1]));
    end
    $display("test parity done");
    conclude();
  end
endmodule : bfc_port_control_tb
